/* hw/m13_csr_regs.svh */
// register offsets, field positions, reset values and filter counts for the control bank
// Contract
// - receive alarm word has no queue; each new message overwrites and sets new flag
// - with new flag set, idle flag reads 0 when channel busy, 1 when idle
// - loop command bit 7 launches; bit 6 chooses connect (1) or disconnect (0)
// - loop command bits 1..0 select the DS1 inside the group; channel 1 is 001/00
// - all-channel decode on zero channel field or any disconnect; completion clears bit 7 only
// - config bit 7 set floats all 28 receive DS1 data outputs
// - config bit 6 picks receive (0) or transmit (1) DS1 channels for loss monitoring
// - config bits 5..4 choose which DS3 alarms force DS1 all-ones insertion
// - config bits 3..0 choose the M13 remote loopback request method
// - three-bit receive DS3 AIS selector picks detection pattern; code 111 unused
// - two-bit transmit DS3 AIS selector picks the generated pattern
// - 8-bit saturating C1-zero counter, held in LOS or OOF, clears on read
// - 8-bit saturating M-bit error counter, held in LOS or OOF, clears on read
// - X-bit filter: mod-16 ones, mod-4 zeros; either maturing resets both
// - C-bits-zero flag latches after 7 frames of 30 or fewer ones
// - severe frame flag latches on 3 errored F-bits of last 16
// - receive AIS uses C-bit filter for codes 000 and 001, X-bit filter for 001
`ifndef M13_CSR_REGS_SVH
`define M13_CSR_REGS_SVH
`define ADDR_FEAC_RX     8'h1d
`define ADDR_LOOP_CMD    8'h1e
`define ADDR_INIT        8'h1f
`define ADDR_DS1_CFG     8'h20
`define ADDR_AIS_SEL     8'h21
`define ADDR_C1Z_CNT     8'h22
`define ADDR_MERR_CNT    8'h23
`define ADDR_AIS_SEF     8'h24
`define LOOP_GO_BIT      7
`define LOOP_CONN_BIT    6
`define CFG_FLOAT_BIT    7
`define CFG_LOSSEL_BIT   6
`define STAT_XONE_BIT    7
`define STAT_CZERO_BIT   6
`define STAT_SEF_BIT     0
`define INIT_RESET_CODE  8'hf0
`define INIT_PRESET_CODE 8'h00
`define REG_RESET_VAL    8'h00
`define XONE_MATURE      5'd16
`define XZERO_MATURE     3'd4
`define CZERO_FRAMES     3'd7
`define CZERO_MAX_ONES   6'd30
`define SEF_WINDOW       16
`define SEF_ERRORS       5'd3
`define AUX_DIV          8
`endif

/* hw/m13_csr_pkg.sv */
// types shared by the control bank modules
package m13_csr_pkg;
   typedef enum logic [1:0] {
      INIT_IDLE,
      INIT_RESET,
      INIT_PRESET
   } init_state_t;
endpackage : m13_csr_pkg

/* hw/ais_clk_if.sv */
// carrier between control bank and auxiliary-clock tick divider
`timescale 1ns/1ps
`default_nettype none
interface ais_clk_if;
   logic aux_sync;
   logic ais_tick;
   modport gen (input aux_sync, output ais_tick);
   modport use_side (output aux_sync, input ais_tick);
endinterface : ais_clk_if
`default_nettype wire

/* hw/ais_tick_gen.sv */
// derives the DS1 AIS bit enable from the synchronised auxiliary clock
`timescale 1ns/1ps
`default_nettype none
`include "m13_csr_regs.svh"
module ais_tick_gen #(
   parameter int DIV = `AUX_DIV
) (
   input  wire logic    sys_clk,
   input  wire logic    nrst,
   ais_clk_if.gen       ck
);
   logic       aux_prev_q;
   logic [7:0] div_q;
   // divide rising edges of the auxiliary clock into one-cycle ticks
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         aux_prev_q <= 1'b0;
         div_q      <= 8'h00;
      end else begin
         aux_prev_q <= ck.aux_sync;
         if (ck.aux_sync && !aux_prev_q) begin
            div_q <= (div_q == 8'(DIV - 1)) ? 8'h00 : div_q + 8'h01;
         end
      end
   end
   assign ck.ais_tick = ck.aux_sync && !aux_prev_q && (div_q == 8'h00);
endmodule : ais_tick_gen
`default_nettype wire

/* hw/m13_control_status_regs.sv */
// upper control and status register bank of the DS3/DS1 multiplexer
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "m13_csr_regs.svh"
module m13_control_status_regs #(
   parameter int NCH = 28
) (
   input  wire logic           sys_clk,
   input  wire logic           nrst,
   input  wire logic [7:0]     addr,
   input  wire logic [7:0]     wdata,
   input  wire logic           wr_stb,
   input  wire logic           rd_stb,
   output logic [7:0]          rdata,
   input  wire logic           feac_valid,
   input  wire logic [5:0]     feac_code,
   input  wire logic           feac_busy,
   input  wire logic           loop_done,
   output logic                loop_cmd_valid,
   output logic                loop_connect_select,
   output logic [2:0]          loop_group_select,
   output logic [1:0]          loop_tributary_select,
   output logic                loop_all,
   output logic                init_reset,
   output logic                init_preset,
   input  wire logic [NCH-1:0] rx_tributary_data_in,
   output logic [NCH-1:0]      rx_tributary_data_out,
   output logic [NCH-1:0]      rx_tributary_data_oe,
   output logic                tributary_los_source_select,
   input  wire logic           rx_high_out_of_frame,
   input  wire logic           rx_high_ais_alarm,
   input  wire logic           rx_high_signal_loss,
   input  wire logic           rx_high_clock_fail,
   input  wire logic           aux_reference_clock,
   output logic                tributary_ais_insert,
   output logic                tributary_ais_tick,
   output logic [3:0]          remote_loop_method,
   output logic [2:0]          rx_high_ais_select,
   output logic [1:0]          tx_high_ais_select,
   input  wire logic           frame_tick,
   input  wire logic           c1_bit_stb,
   input  wire logic           c1_bit_zero,
   input  wire logic           mbit_error_stb,
   input  wire logic           cbit_one_stb,
   input  wire logic           xpair_stb,
   input  wire logic           xpair_one,
   input  wire logic           xpair_zero,
   input  wire logic           fbit_stb,
   input  wire logic           fbit_error,
   output logic                ais_filter_ok
);
   logic [7:0]  feac_q;
   logic [7:0]  loop_q;
   logic [7:0]  init_q;
   logic [7:0]  cfg_q;
   logic [4:0]  ais_q;
   logic [7:0]  c1z_q;
   logic [7:0]  merr_q;
   logic        xone_q;
   logic        czero_q;
   logic        sef_q;
   logic [4:0]  xone_cnt_q;
   logic [2:0]  xzero_cnt_q;
   logic [5:0]  cone_cnt_q;
   logic [2:0]  cframes_q;
   logic [15:0] fwin_q;
   logic [7:0]  rdata_q;
   logic        rd_feac;
   logic        rd_c1z;
   logic        rd_merr;
   logic        rd_stat;
   logic        wr_loop, wr_init, wr_cfg, wr_ais;
   logic        hold_cnt;
   logic        xone_set;
   logic        czero_set;
   logic        sef_set;
   logic        fwin_bad;
   logic        aux_s1_q;
   logic        aux_s2_q;
   logic [7:0]  stat_word;
   m13_csr_pkg::init_state_t init_st_q;
   ais_clk_if   ck ();

   // saturating increment shared by both error counters
   function automatic logic [7:0] sat_inc(input logic [7:0] v);
      sat_inc = (v == 8'hff) ? v : v + 8'h01;
   endfunction : sat_inc

   // population count of the F-bit window
   function automatic logic [4:0] ones16(input logic [15:0] v);
      ones16 = 5'd0;
      for (int i = 0; i < 16; i++) begin
         ones16 = ones16 + {4'd0, v[i]};
      end
   endfunction : ones16

   // read strobes for clear-on-read locations
   assign rd_feac  = rd_stb && (addr == `ADDR_FEAC_RX);
   assign rd_c1z   = rd_stb && (addr == `ADDR_C1Z_CNT);
   assign rd_merr  = rd_stb && (addr == `ADDR_MERR_CNT);
   assign rd_stat  = rd_stb && (addr == `ADDR_AIS_SEF);
   assign hold_cnt = rx_high_signal_loss || rx_high_out_of_frame;

   // write strobes for the writable locations
   assign wr_loop  = wr_stb && (addr == `ADDR_LOOP_CMD);
   assign wr_init  = wr_stb && (addr == `ADDR_INIT);
   assign wr_cfg   = wr_stb && (addr == `ADDR_DS1_CFG);
   assign wr_ais   = wr_stb && (addr == `ADDR_AIS_SEL);

   // received alarm word: overwrite, set new flag, track idle
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         feac_q <= `REG_RESET_VAL;
      end else if (feac_valid) begin
         feac_q <= {!feac_busy, 1'b1, feac_code};
      end else begin
         feac_q[7] <= !feac_busy;
         if (rd_feac) begin
            feac_q[6] <= 1'b0;
         end
      end
   end

   // loop command register: software launches, completion clears go bit
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         loop_q <= `REG_RESET_VAL;
      end else if (wr_loop) begin
         loop_q <= {wdata[7:6], 1'b0, wdata[4:0]};
      end else if (loop_done && loop_q[`LOOP_GO_BIT]) begin
         loop_q[`LOOP_GO_BIT] <= 1'b0;
      end
   end
   assign loop_cmd_valid        = loop_q[`LOOP_GO_BIT];
   assign loop_connect_select   = loop_q[`LOOP_CONN_BIT];
   assign loop_group_select     = loop_q[4:2];
   assign loop_tributary_select = loop_q[1:0];
   assign loop_all = (loop_q[4:0] == 5'd0) || !loop_q[`LOOP_CONN_BIT];

   // init register and the reset-then-preset sequencer
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         init_q    <= `REG_RESET_VAL;
         init_st_q <= m13_csr_pkg::INIT_IDLE;
      end else if (wr_init) begin
         init_q <= wdata;
         case (init_st_q)
            m13_csr_pkg::INIT_IDLE, m13_csr_pkg::INIT_PRESET: begin
               init_st_q <= (wdata == `INIT_RESET_CODE) ? m13_csr_pkg::INIT_RESET
                                                         : m13_csr_pkg::INIT_IDLE;
            end
            m13_csr_pkg::INIT_RESET: begin
               init_st_q <= (wdata == `INIT_PRESET_CODE) ? m13_csr_pkg::INIT_PRESET
                                                          : m13_csr_pkg::INIT_RESET;
            end
            default: begin
               init_st_q <= m13_csr_pkg::INIT_IDLE;
            end
         endcase
      end
   end
   // reset pulse on F0, preset pulse on the following 00
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         init_reset  <= 1'b0;
         init_preset <= 1'b0;
      end else begin
         init_reset  <= wr_init && wdata == `INIT_RESET_CODE;
         init_preset <= wr_init && wdata == `INIT_PRESET_CODE
                        && init_st_q == m13_csr_pkg::INIT_RESET;
      end
   end

   // plain read/write configuration registers
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         cfg_q <= `REG_RESET_VAL;
         ais_q <= 5'd0;
      end else if (wr_cfg) begin
         cfg_q <= wdata;
      end else if (wr_ais) begin
         ais_q <= wdata[4:0];
      end
   end
   assign tributary_los_source_select = cfg_q[`CFG_LOSSEL_BIT];
   assign remote_loop_method          = cfg_q[3:0];
   assign rx_high_ais_select          = ais_q[4:2];
   assign tx_high_ais_select          = ais_q[1:0];

   // registered DS1 data outputs with float control
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         rx_tributary_data_out <= '0;
         rx_tributary_data_oe  <= '0;
      end else begin
         rx_tributary_data_out <= rx_tributary_data_in;
         rx_tributary_data_oe  <= {NCH{!cfg_q[`CFG_FLOAT_BIT]}};
      end
   end

   // alarm policy for all-ones insertion
   always_comb begin
      case (cfg_q[5:4])
         2'b00: tributary_ais_insert = rx_high_out_of_frame || rx_high_ais_alarm
                                       || rx_high_signal_loss || rx_high_clock_fail;
         2'b01: tributary_ais_insert = rx_high_ais_alarm || rx_high_clock_fail;
         2'b10: tributary_ais_insert = rx_high_signal_loss;
         default: tributary_ais_insert = 1'b0;
      endcase
   end

   // auxiliary clock synchroniser feeding the tick divider
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         aux_s1_q <= 1'b0;
         aux_s2_q <= 1'b0;
      end else begin
         aux_s1_q <= aux_reference_clock;
         aux_s2_q <= aux_s1_q;
      end
   end
   assign ck.aux_sync = aux_s2_q;
   ais_tick_gen #(.DIV(`AUX_DIV)) u_tick (
      .sys_clk (sys_clk),
      .nrst    (nrst),
      .ck      (ck.gen)
   );
   assign tributary_ais_tick = ck.ais_tick && tributary_ais_insert;

   // C1-zero and M-bit error counters, held in LOS/OOF, clear on read
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         c1z_q  <= 8'h00;
         merr_q <= 8'h00;
      end else begin
         // a read and an event together leave a count of one
         if (c1_bit_stb && c1_bit_zero && !hold_cnt) begin
            c1z_q <= rd_c1z ? 8'h01 : sat_inc(c1z_q);
         end else if (rd_c1z) begin
            c1z_q <= 8'h00;
         end
         if (mbit_error_stb && !hold_cnt) begin
            merr_q <= rd_merr ? 8'h01 : sat_inc(merr_q);
         end else if (rd_merr) begin
            merr_q <= 8'h00;
         end
      end
   end

   // X-bit pair filter counters
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         xone_cnt_q  <= 5'd0;
         xzero_cnt_q <= 3'd0;
      end else if (xpair_stb) begin
         if (xone_set || (xpair_zero && xzero_cnt_q == `XZERO_MATURE - 3'd1)) begin
            xone_cnt_q  <= 5'd0;
            xzero_cnt_q <= 3'd0;
         end else if (xpair_one) begin
            xone_cnt_q <= xone_cnt_q + 5'd1;
         end else if (xpair_zero) begin
            xzero_cnt_q <= xzero_cnt_q + 3'd1;
         end
      end
   end
   assign xone_set = xpair_stb && xpair_one && (xone_cnt_q == `XONE_MATURE - 5'd1);

   // C-bit ones per frame and contiguous low-ones frame count
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         cone_cnt_q <= 6'd0;
         cframes_q  <= 3'd0;
      end else if (frame_tick) begin
         cone_cnt_q <= 6'd0;
         if (cone_cnt_q <= `CZERO_MAX_ONES) begin
            cframes_q <= czero_set ? cframes_q : cframes_q + 3'd1;
         end else begin
            cframes_q <= 3'd0;
         end
      end else if (cbit_one_stb && cone_cnt_q != 6'h3f) begin
         cone_cnt_q <= cone_cnt_q + 6'd1;
      end
   end
   assign czero_set = frame_tick && cone_cnt_q <= `CZERO_MAX_ONES
                      && cframes_q >= `CZERO_FRAMES - 3'd1;

   // sliding window of F-bit errors
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         fwin_q <= 16'h0000;
      end else if (fbit_stb) begin
         fwin_q <= {fwin_q[14:0], fbit_error};
      end
   end
   // window is judged every cycle, so the flag relatches while bad
   assign fwin_bad = ones16(fwin_q) >= `SEF_ERRORS;
   assign sef_set  = fwin_bad;

   // latched flags: set wins over the read clear
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         xone_q  <= 1'b0;
         czero_q <= 1'b0;
         sef_q   <= 1'b0;
      end else begin
         xone_q  <= xone_set  || (xone_q  && !rd_stat);
         czero_q <= czero_set || (czero_q && !rd_stat);
         sef_q   <= sef_set   || (sef_q   && !rd_stat);
      end
   end

   // detection qualification from the filter flags
   always_comb begin
      case (ais_q[4:2])
         3'b000:  ais_filter_ok = czero_q;
         3'b001:  ais_filter_ok = czero_q && xone_q;
         default: ais_filter_ok = 1'b1;
      endcase
   end

   // status byte assembled from the latched flags
   always_comb begin
      stat_word                  = 8'h00;
      stat_word[`STAT_XONE_BIT]  = xone_q;
      stat_word[`STAT_CZERO_BIT] = czero_q;
      stat_word[`STAT_SEF_BIT]   = sef_q;
   end

   // read data mux, answered one cycle after the strobe
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         rdata_q <= 8'h00;
      end else if (rd_stb) begin
         case (addr)
            `ADDR_FEAC_RX:  rdata_q <= feac_q;
            `ADDR_LOOP_CMD: rdata_q <= loop_q;
            `ADDR_INIT:     rdata_q <= init_q;
            `ADDR_DS1_CFG:  rdata_q <= cfg_q;
            `ADDR_AIS_SEL:  rdata_q <= {3'b000, ais_q};
            `ADDR_C1Z_CNT:  rdata_q <= c1z_q;
            `ADDR_MERR_CNT: rdata_q <= merr_q;
            `ADDR_AIS_SEF:  rdata_q <= stat_word;
            default:        rdata_q <= 8'h00;
         endcase
      end else begin
         rdata_q <= 8'h00;
      end
   end
   assign rdata = rdata_q;
endmodule : m13_control_status_regs
`default_nettype wire

/* bench/m13_csr_props.sv */
// port checker for the control and status bank
`timescale 1ns/1ps
`default_nettype none
module m13_csr_props #(
   parameter int NCH = 28
) (
   input wire logic           sys_clk,
   input wire logic           nrst,
   input wire logic [7:0]     addr,
   input wire logic [7:0]     wdata,
   input wire logic           wr_stb,
   input wire logic           loop_done,
   input wire logic           loop_cmd_valid,
   input wire logic           loop_connect_select,
   input wire logic [2:0]     loop_group_select,
   input wire logic [1:0]     loop_tributary_select,
   input wire logic           loop_all,
   input wire logic           init_reset,
   input wire logic [NCH-1:0] rx_tributary_data_oe,
   input wire logic           tributary_los_source_select,
   input wire logic           rx_high_out_of_frame,
   input wire logic           rx_high_ais_alarm,
   input wire logic           rx_high_signal_loss,
   input wire logic           rx_high_clock_fail,
   input wire logic           tributary_ais_insert,
   input wire logic [2:0]     rx_high_ais_select,
   input wire logic [1:0]     tx_high_ais_select,
   input wire logic           ais_filter_ok
);
   logic [7:0] wd_q;
   logic [1:0] pol_q;
   logic [3:0] al;
   logic       ins_exp;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   // last write data and captured insertion policy
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         wd_q <= 8'h00;
         pol_q <= 2'h0;
      end else begin
         wd_q <= wdata;
         if (wr_stb && addr == 8'h20) pol_q <= wdata[5:4];
      end
   end
   // expected insertion from policy and alarms
   assign al = {rx_high_out_of_frame, rx_high_ais_alarm, rx_high_signal_loss, rx_high_clock_fail};
   always_comb begin
      case (pol_q)
         2'h0: ins_exp = |al;
         2'h1: ins_exp = al[2] | al[0];
         2'h2: ins_exp = al[1];
         default: ins_exp = 1'b0;
      endcase
   end
   init_reset_pulse_a: assert property (
      wr_stb && addr == 8'h1f && wdata == 8'hf0 |=> init_reset)
      else $error("no reset pulse after init write");
   outputs_float_a: assert property (
      wr_stb && addr == 8'h20 && wdata[7] |=> ##1 rx_tributary_data_oe == '0)
      else $error("outputs still driven while floated");
   outputs_drive_a: assert property (
      wr_stb && addr == 8'h20 && !wdata[7] |=> ##1 rx_tributary_data_oe == {NCH{1'b1}})
      else $error("outputs not driven in normal mode");
   los_select_a: assert property (
      wr_stb && addr == 8'h20 |=> tributary_los_source_select == wd_q[6])
      else $error("loss source select mismatch");
   ais_policy_a: assert property (tributary_ais_insert == ins_exp)
      else $error("insertion does not follow policy");
   loop_fields_a: assert property (
      wr_stb && addr == 8'h1e |=> {loop_cmd_valid, loop_connect_select, loop_group_select,
      loop_tributary_select} == {wd_q[7:6], wd_q[4:0]})
      else $error("loop command fields mismatch");
   go_clear_a: assert property (
      loop_done && !(wr_stb && addr == 8'h1e) |=> !loop_cmd_valid && $stable(loop_group_select))
      else $error("go bit not cleared alone on completion");
   loop_all_a: assert property (
      loop_all == (!loop_connect_select || {loop_group_select, loop_tributary_select} == 5'h00))
      else $error("all-channel decode mismatch");
   ais_select_a: assert property (
      wr_stb && addr == 8'h21 |=> {rx_high_ais_select, tx_high_ais_select} == wd_q[4:0])
      else $error("ais selector mismatch");
   filter_bypass_a: assert property (rx_high_ais_select[2:1] != 2'h0 |-> ais_filter_ok)
      else $error("filter gates a pattern mode");
endmodule : m13_csr_props
`default_nettype wire

/* bench/m13_control_status_regs_tb_top.sv */
// self-checking bench for the control and status bank
`timescale 1ns/1ps
`default_nettype none
bind m13_control_status_regs m13_csr_props #(.NCH(NCH)) chk_u (
   .sys_clk, .nrst, .addr, .wdata, .wr_stb, .loop_done, .loop_cmd_valid, .loop_connect_select,
   .loop_group_select, .loop_tributary_select, .loop_all, .init_reset, .rx_tributary_data_oe,
   .tributary_los_source_select, .rx_high_out_of_frame, .rx_high_ais_alarm, .rx_high_signal_loss,
   .rx_high_clock_fail, .tributary_ais_insert, .rx_high_ais_select, .tx_high_ais_select,
   .ais_filter_ok);
module m13_control_status_regs_tb_top;
   localparam int NCH = 28;
   localparam int S_FEAC = 0, S_DONE = 1, S_FRAME = 2, S_C1 = 3, S_MERR = 4, S_CONE = 5;
   localparam int S_XP = 6, S_FB = 7;
   localparam logic [7:0] CMDS [6] = '{8'hc4, 8'hc5, 8'hdf, 8'hc0, 8'h80, 8'h9f};
   localparam logic [3:0] MASKS [4] = '{4'hf, 4'h5, 4'h2, 4'h0};
   logic           sys_clk = 1'b0, nrst = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0;
   logic [7:0]     addr = 8'h00, wdata = 8'h00, stb = 8'h00, rdata;
   logic [5:0]     feac_code = 6'h00;
   logic           feac_busy = 1'b1, c1_bit_zero = 1'b1, fbit_error = 1'b0, aux = 1'b0;
   logic           xpair_one = 1'b0, xpair_zero = 1'b0, oof = 1'b0, ais = 1'b0;
   logic           los = 1'b0, ckf = 1'b0;
   logic [NCH-1:0] rx_tributary_data_in = 28'h5a5a5a5, rx_tributary_data_out, rx_tributary_data_oe;
   logic           loop_cmd_valid, loop_connect_select, loop_all, init_reset, init_preset;
   logic [2:0]     loop_group_select, rx_high_ais_select;
   logic [1:0]     loop_tributary_select, tx_high_ais_select;
   logic [3:0]     remote_loop_method;
   logic           tributary_los_source_select, tributary_ais_insert, tributary_ais_tick;
   logic           ais_filter_ok;
   int             mismatches = 0, compares = 0, presets = 0;
   m13_control_status_regs #(.NCH(NCH)) dut_u (
      .sys_clk, .nrst, .addr, .wdata, .wr_stb, .rd_stb, .rdata, .feac_valid(stb[0]), .feac_code,
      .feac_busy, .loop_done(stb[1]), .loop_cmd_valid, .loop_connect_select, .loop_group_select,
      .loop_tributary_select, .loop_all, .init_reset, .init_preset, .rx_tributary_data_in,
      .rx_tributary_data_out, .rx_tributary_data_oe, .tributary_los_source_select,
      .rx_high_out_of_frame(oof), .rx_high_ais_alarm(ais), .rx_high_signal_loss(los),
      .rx_high_clock_fail(ckf), .aux_reference_clock(aux), .tributary_ais_insert,
      .tributary_ais_tick, .remote_loop_method, .rx_high_ais_select, .tx_high_ais_select,
      .frame_tick(stb[2]), .c1_bit_stb(stb[3]), .c1_bit_zero, .mbit_error_stb(stb[4]),
      .cbit_one_stb(stb[5]), .xpair_stb(stb[6]), .xpair_one, .xpair_zero, .fbit_stb(stb[7]),
      .fbit_error, .ais_filter_ok);
   // clock and preset pulse counter
   always #12.5 sys_clk = ~sys_clk;
   always @(negedge sys_clk) if (init_preset === 1'b1) presets++;
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task wr(input logic [7:0] a, input logic [7:0] d);
      addr <= a;
      wdata <= d;
      wr_stb <= 1'b1;
      @(posedge sys_clk);
      wr_stb <= 1'b0;
      @(posedge sys_clk);
   endtask : wr
   task rd_chk(input logic [7:0] a, input logic [7:0] exp);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge sys_clk);
      rd_stb <= 1'b0;
      #1 chk($sformatf("reg %h", a), 32'(rdata), 32'(exp));
      @(posedge sys_clk);
   endtask : rd_chk
   // strobe one event line for n cycles
   task ev(input int k, input int n);
      stb[k] <= 1'b1;
      repeat (n) @(posedge sys_clk);
      stb[k] <= 1'b0;
      @(posedge sys_clk);
   endtask : ev
   task t_feac;
      feac_code <= 6'h15;
      ev(S_FEAC, 1);
      feac_code <= 6'h2a;
      ev(S_FEAC, 1);
      rd_chk(8'h1d, 8'h6a);
      feac_busy <= 1'b0;
      @(posedge sys_clk);
      rd_chk(8'h1d, 8'haa);
      feac_code <= 6'h01;
      ev(S_FEAC, 1);
      rd_chk(8'h1d, 8'hc1);
   endtask : t_feac
   task t_loop;
      foreach (CMDS[i]) begin
         wr(8'h1e, CMDS[i]);
         chk("go", 32'(loop_cmd_valid), 32'(CMDS[i][7]));
         chk("conn", 32'(loop_connect_select), 32'(CMDS[i][6]));
         chk("group", 32'(loop_group_select), 32'(CMDS[i][4:2]));
         chk("trib", 32'(loop_tributary_select), 32'(CMDS[i][1:0]));
         chk("all", 32'(loop_all), 32'(CMDS[i][4:0] == 5'h00 || !CMDS[i][6]));
         ev(S_DONE, 1);
         rd_chk(8'h1e, CMDS[i] & 8'h7f);
      end
   endtask : t_loop
   task t_cfg;
      wr(8'h1f, 8'hf0);
      rd_chk(8'h1f, 8'hf0);
      wr(8'h1f, 8'h00);
      chk("presets", 32'(presets), 32'h1);
      wr(8'h20, 8'h80);
      @(posedge sys_clk);
      chk("oe float", 32'(rx_tributary_data_oe), 32'h0);
      wr(8'h20, 8'h49);
      @(posedge sys_clk);
      chk("oe drive", 32'(rx_tributary_data_oe), 32'h0fffffff);
      chk("data out", 32'(rx_tributary_data_out), 32'h05a5a5a5);
      chk("los sel", 32'(tributary_los_source_select), 32'h1);
      chk("method", 32'(remote_loop_method), 32'h9);
      rd_chk(8'h20, 8'h49);
      wr(8'h21, 8'hff);
      chk("ais sel", 32'({rx_high_ais_select, tx_high_ais_select}), 32'h1f);
      rd_chk(8'h21, 8'h1f);
      wr(8'h21, 8'h00);
   endtask : t_cfg
   task t_policy;
      for (int p = 0; p < 4; p++) begin
         wr(8'h20, 8'(p << 4));
         for (int i = 0; i < 4; i++) begin
            {oof, ais, los, ckf} <= 4'(4'h8 >> i);
            @(posedge sys_clk);
            chk("insert", 32'(tributary_ais_insert), 32'(MASKS[p][3 - i]));
         end
         {oof, ais, los, ckf} <= 4'h0;
      end
   endtask : t_policy
   // aux clock toggles every third cycle while out of frame
   task t_tick(input logic [7:0] cfg, input logic on);
      int ticks;
      ticks = 0;
      wr(8'h20, cfg);
      oof <= 1'b1;
      for (int c = 0; c < 240; c++) begin
         if (c % 3 == 0) aux <= ~aux;
         @(posedge sys_clk);
         if (tributary_ais_tick === 1'b1) ticks++;
      end
      oof <= 1'b0;
      chk("ticks", 32'(ticks > 0), 32'(on));
   endtask : t_tick
   task t_count(input int k, input logic [7:0] a);
      ev(k, 3);
      rd_chk(a, 8'h03);
      rd_chk(a, 8'h00);
      los <= 1'b1;
      ev(k, 2);
      {los, oof} <= 2'b01;
      ev(k, 2);
      oof <= 1'b0;
      wr(a, 8'h55);
      rd_chk(a, 8'h00);
      ev(k, 260);
      stb[k] <= 1'b1;
      rd_chk(a, 8'hff);
      stb[k] <= 1'b0;
      rd_chk(a, 8'h02);
   endtask : t_count
   task t_filters;
      xpair_one <= 1'b1;
      ev(S_XP, 15);
      {xpair_one, xpair_zero} <= 2'b01;
      ev(S_XP, 4);
      {xpair_one, xpair_zero} <= 2'b10;
      ev(S_XP, 15);
      rd_chk(8'h24, 8'h00);
      ev(S_XP, 1);
      rd_chk(8'h24, 8'h80);
      rd_chk(8'h24, 8'h00);
      ev(S_CONE, 31);
      ev(S_FRAME, 1);
      for (int f = 0; f < 7; f++) begin
         chk("filter", 32'(ais_filter_ok), 32'h0);
         ev(S_CONE, 30);
         ev(S_FRAME, 1);
      end
      chk("filter", 32'(ais_filter_ok), 32'h1);
      wr(8'h21, 8'h04);
      chk("filter x", 32'(ais_filter_ok), 32'h0);
      wr(8'h21, 8'h08);
      chk("filter off", 32'(ais_filter_ok), 32'h1);
      rd_chk(8'h24, 8'h40);
      fbit_error <= 1'b1;
      ev(S_FB, 2);
      rd_chk(8'h24, 8'h00);
      ev(S_FB, 1);
      rd_chk(8'h24, 8'h01);
      rd_chk(8'h24, 8'h01);
      fbit_error <= 1'b0;
      ev(S_FB, 16);
      rd_chk(8'h24, 8'h01);
      rd_chk(8'h24, 8'h00);
   endtask : t_filters
   task report_and_stop;
      if (mismatches == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : report_and_stop
   // watchdog against a hung sequence
   initial begin
      repeat (60000) @(posedge sys_clk);
      mismatches++;
      report_and_stop();
   end
   // main sequence
   initial begin
      repeat (20) @(posedge sys_clk);
      chk("oe reset", 32'(rx_tributary_data_oe), 32'h0);
      nrst <= 1'b1;
      @(posedge sys_clk);
      for (int a = 8'h1d; a <= 8'h24; a++) rd_chk(8'(a), 8'h00);
      rd_chk(8'h30, 8'h00);
      t_feac();
      t_loop();
      t_cfg();
      t_policy();
      t_tick(8'h00, 1'b1);
      t_tick(8'h30, 1'b0);
      t_count(S_C1, 8'h22);
      t_count(S_MERR, 8'h23);
      t_filters();
      report_and_stop();
   end
endmodule : m13_control_status_regs_tb_top
`default_nettype wire
